// *** common/cmi_pkg.sv ***
// Constants and types shared by the module interrupt controller
package cmi_pkg;

  // Register byte offsets on the APB slave
  localparam logic [11:0] CFG_OFF  = 12'h000;
  localparam logic [11:0] PEND_OFF = 12'h004;
  localparam logic [11:0] MASK_OFF = 12'h008;
  localparam logic [11:0] INSV_OFF = 12'h00C;

  // Configuration register layout
  localparam int unsigned CFG_W      = 24;
  localparam logic [23:0] CFG_RST    = 24'h000000;
  localparam logic [23:0] CFG_WMASK  = 24'hFFFFE1;
  localparam int unsigned SLOT_LSB   = 16;
  localparam int unsigned LEVEL_LSB  = 13;
  localparam int unsigned TOP_LSB    = 8;
  localparam int unsigned BASE_LSB   = 5;
  localparam int unsigned SPREAD_BIT = 0;

  // Source bits; reserved codes never hold a source
  localparam logic [31:0] SRC_RST   = 32'h00000000;
  localparam logic [31:0] SRC_VALID = 32'hFFF6DEFE;
  localparam logic [31:0] SCC_BITS  = 32'h78000000;
  localparam logic [4:0]  SCC1_CODE = 5'h1E;

  // Table positions of the channel slots
  localparam logic [4:0] POS_A     = 5'h1E;
  localparam logic [4:0] POS_B_GRP = 5'h1D;
  localparam logic [4:0] POS_C_GRP = 5'h1C;
  localparam logic [4:0] POS_D_GRP = 5'h1B;
  localparam logic [4:0] POS_B_SPR = 5'h13;
  localparam logic [4:0] POS_C_SPR = 5'h0D;
  localparam logic [4:0] POS_D_SPR = 5'h08;

  localparam logic [4:0] NO_TOP    = 5'h1F;
  localparam logic [4:0] ERR_CODE  = 5'h00;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [5:0] TOP_POS   = 6'h20;

  typedef enum logic [0:0] {
    CMI_IDLE   = 1'b0,
    CMI_ANSWER = 1'b1
  } cmi_ack_e;

endpackage : cmi_pkg

// *** rtl/cmi_prienc.sv ***
// Priority encoder: index of the highest set bit
`timescale 1ns/1ps
module cmi_prienc #(
  parameter int unsigned W  = 33,
  parameter int unsigned IW = 6
) (
  input  wire logic [W-1:0]  vec,
  output logic               found,
  output logic [IW-1:0]      index
);

  always_comb
  begin
    found = 1'b0;
    index = '0;
    for (int i = 0; i < W; i++)
    begin
      if (vec[i])
      begin
        found = 1'b1;
        index = IW'(i);
      end
    end
  end

endmodule : cmi_prienc

// *** rtl/cmi_slot_map.sv ***
// Reorders source bits into priority-table positions
`timescale 1ns/1ps
module cmi_slot_map (
  input  wire logic [31:0] src_vec,
  input  wire logic [7:0]  slot_sel,
  input  wire logic        spread,
  output logic [31:0]      pos_vec
);

  // Request of the channel named by a slot select field
  function automatic logic chan_bit(input logic [31:0] src, input logic [1:0] sel);
    logic [4:0] code;
    code = cmi_pkg::SCC1_CODE - {3'h0, sel};
    return src[code];
  endfunction : chan_bit

  always_comb
  begin
    pos_vec = src_vec & ~cmi_pkg::SCC_BITS;
    pos_vec[cmi_pkg::POS_A] = chan_bit(src_vec, slot_sel[1:0]);
    if (spread)
    begin
      pos_vec[cmi_pkg::POS_B_SPR] = chan_bit(src_vec, slot_sel[3:2]);
      pos_vec[cmi_pkg::POS_C_SPR] = chan_bit(src_vec, slot_sel[5:4]);
      pos_vec[cmi_pkg::POS_D_SPR] = chan_bit(src_vec, slot_sel[7:6]);
    end
    else
    begin
      pos_vec[cmi_pkg::POS_B_GRP] = chan_bit(src_vec, slot_sel[3:2]);
      pos_vec[cmi_pkg::POS_C_GRP] = chan_bit(src_vec, slot_sel[5:4]);
      pos_vec[cmi_pkg::POS_D_GRP] = chan_bit(src_vec, slot_sel[7:6]);
    end
  end

endmodule : cmi_slot_map

// *** rtl/cmi_ctrl.sv ***
// Module interrupt controller: priority, vectoring and APB registers
`timescale 1ns/1ps
module cmi_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [31:0] src_event,
  output logic [2:0]       irq_level,
  input  wire logic        iack_req,
  input  wire logic [2:0]  iack_level,
  output logic             iack_valid,
  output logic [7:0]       iack_vector
);

  logic [23:0]       cfg_ff;
  logic [23:0]       nxt_cfg;
  logic [31:0]       pend_ff;
  logic [31:0]       nxt_pend;
  logic [31:0]       mask_ff;
  logic [31:0]       nxt_mask;
  logic [31:0]       insv_ff;
  logic [31:0]       nxt_insv;
  logic [31:0]       prdata_ff;
  logic [31:0]       nxt_prdata;
  logic [2:0]        irq_level_ff;
  logic [2:0]        nxt_irq_level;
  logic [7:0]        vector_ff;
  logic [7:0]        nxt_vector;
  cmi_pkg::cmi_ack_e state_ff;
  cmi_pkg::cmi_ack_e nxt_state;

  // Configuration fields
  wire logic [7:0]  slot_sel = cfg_ff[cmi_pkg::SLOT_LSB +: 8];
  wire logic [2:0]  level    = cfg_ff[cmi_pkg::LEVEL_LSB +: 3];
  wire logic [4:0]  top_src  = cfg_ff[cmi_pkg::TOP_LSB +: 5];
  wire logic [2:0]  base     = cfg_ff[cmi_pkg::BASE_LSB +: 3];
  wire logic        spread   = cfg_ff[cmi_pkg::SPREAD_BIT];
  wire logic        level_on = level != cmi_pkg::LEVEL_OFF;
  wire logic        top_used = top_src != cmi_pkg::NO_TOP;

  // Candidate set: pending and enabled
  wire logic [31:0] eligible = pend_ff & mask_ff;
  wire logic [31:0] top_hot  = top_used ? (32'h1 << top_src) : 32'h0;

  logic [31:0] req_pos;
  logic [31:0] isr_pos;
  logic        req_found;
  logic [5:0]  req_idx;
  logic        isr_found;
  logic [5:0]  isr_idx;

  // Reorder candidates and in-service bits by table position
  cmi_slot_map u_req_map (
    .src_vec  (eligible & ~top_hot),
    .slot_sel (slot_sel),
    .spread   (spread),
    .pos_vec  (req_pos)
  );

  cmi_slot_map u_isr_map (
    .src_vec  (insv_ff & ~top_hot),
    .slot_sel (slot_sel),
    .spread   (spread),
    .pos_vec  (isr_pos)
  );

  // Top-priority source sits above the whole table
  wire logic [32:0] req_all = {|(eligible & top_hot), req_pos};
  wire logic [32:0] isr_all = {|(insv_ff & top_hot), isr_pos};

  cmi_prienc #(
    .W  (33),
    .IW (6)
  ) u_req_enc (
    .vec   (req_all),
    .found (req_found),
    .index (req_idx)
  );

  cmi_prienc #(
    .W  (33),
    .IW (6)
  ) u_isr_enc (
    .vec   (isr_all),
    .found (isr_found),
    .index (isr_idx)
  );

  // Source number of a table position; channel slots resolve to codes picked by the slot select field
  function automatic logic [4:0] pos_to_src(
    input logic [4:0] pos,
    input logic [7:0] sel,
    input logic       spr
  );
    logic [4:0] src;
    src = pos;
    if (pos == cmi_pkg::POS_A)
      src = cmi_pkg::SCC1_CODE - {3'h0, sel[1:0]};
    else if (pos == (spr ? cmi_pkg::POS_B_SPR : cmi_pkg::POS_B_GRP))
      src = cmi_pkg::SCC1_CODE - {3'h0, sel[3:2]};
    else if (pos == (spr ? cmi_pkg::POS_C_SPR : cmi_pkg::POS_C_GRP))
      src = cmi_pkg::SCC1_CODE - {3'h0, sel[5:4]};
    else if (pos == (spr ? cmi_pkg::POS_D_SPR : cmi_pkg::POS_D_GRP))
      src = cmi_pkg::SCC1_CODE - {3'h0, sel[7:6]};
    return src;
  endfunction : pos_to_src

  // A request opens only above the highest position now in service
  wire logic req_open = req_found && (!isr_found || req_idx > isr_idx);
  wire logic [4:0] win_src = (req_idx == cmi_pkg::TOP_POS) ? top_src
                            : pos_to_src(req_idx[4:0], slot_sel, spread);
  wire logic [4:0] win_code = req_open ? win_src : cmi_pkg::ERR_CODE;

  // Acknowledge handling
  wire logic        ack_hit = iack_req && level_on && (iack_level == level);
  wire logic [31:0] ack_hot = (ack_hit && req_open) ? (32'h1 << win_src) : 32'h0;

  // APB decode
  wire logic sel_cfg  = paddr == cmi_pkg::CFG_OFF;
  wire logic sel_pend = paddr == cmi_pkg::PEND_OFF;
  wire logic sel_mask = paddr == cmi_pkg::MASK_OFF;
  wire logic sel_insv = paddr == cmi_pkg::INSV_OFF;
  wire logic addr_hit = sel_cfg || sel_pend || sel_mask || sel_insv;
  wire logic access   = psel && penable;
  wire logic wr_en    = access && pwrite && addr_hit;
  wire logic rd_setup = psel && !penable && !pwrite;

  wire logic [31:0] clr_pend = (wr_en && sel_pend) ? pwdata : 32'h0;
  wire logic [31:0] clr_insv = (wr_en && sel_insv) ? pwdata : 32'h0;

  wire logic [31:0] rd_mux = sel_cfg  ? {8'h00, cfg_ff}
                           : sel_pend ? pend_ff
                           : sel_mask ? mask_ff
                           : sel_insv ? insv_ff
                           : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = access && !addr_hit;
  assign prdata  = prdata_ff;

  // Next-state logic; hardware sets win over software clears
  assign nxt_cfg     = (wr_en && sel_cfg) ? (pwdata[23:0] & cmi_pkg::CFG_WMASK)
                                          : cfg_ff;
  assign nxt_mask    = (wr_en && sel_mask) ? (pwdata & cmi_pkg::SRC_VALID)
                                           : mask_ff;
  assign nxt_pend    = (pend_ff & ~clr_pend & ~ack_hot)
                     | (src_event & cmi_pkg::SRC_VALID);
  assign nxt_insv    = (insv_ff & ~clr_insv) | ack_hot;
  assign nxt_prdata  = rd_setup ? rd_mux : prdata_ff;
  assign nxt_irq_level = (req_open && level_on) ? level : cmi_pkg::LEVEL_OFF;
  assign nxt_vector  = ack_hit ? {base, win_code} : vector_ff;
  assign nxt_state   = ack_hit ? cmi_pkg::CMI_ANSWER : cmi_pkg::CMI_IDLE;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_ff <= cmi_pkg::CFG_RST;
      pend_ff <= cmi_pkg::SRC_RST;
      mask_ff <= cmi_pkg::SRC_RST;
      insv_ff <= cmi_pkg::SRC_RST;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      pend_ff <= nxt_pend;
      mask_ff <= nxt_mask;
      insv_ff <= nxt_insv;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata_ff <= 32'h00000000;
      irq_level_ff <= cmi_pkg::LEVEL_OFF;
      vector_ff <= 8'h00;
      state_ff <= cmi_pkg::CMI_IDLE;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      irq_level_ff <= nxt_irq_level;
      vector_ff <= nxt_vector;
      state_ff <= nxt_state;
    end
  end

  assign irq_level   = irq_level_ff;
  assign iack_vector = vector_ff;
  assign iack_valid  = state_ff == cmi_pkg::CMI_ANSWER;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (reset);

  chk_ack_answered: assert property (
    ack_hit |=> iack_valid)
    else $error("acknowledge at own level got no answer");

  chk_vector_base: assert property (
    ack_hit |=> iack_vector[7:5] == $past(base))
    else $error("vector upper bits differ from base field");

  chk_error_vector: assert property (
    (ack_hit && !req_open) |=> iack_vector[4:0] == cmi_pkg::ERR_CODE)
    else $error("error code not given with nothing eligible");

  chk_no_reserved: assert property (
    iack_valid |-> (iack_vector[4:0] == cmi_pkg::ERR_CODE
                    || cmi_pkg::SRC_VALID[iack_vector[4:0]]))
    else $error("reserved code issued as vector");

  chk_level_off: assert property (
    (!level_on)[*2] |-> irq_level == cmi_pkg::LEVEL_OFF)
    else $error("request raised with level zero");

  chk_mask_gate: assert property (
    (irq_level != cmi_pkg::LEVEL_OFF) |-> $past(|(pend_ff & mask_ff)))
    else $error("request raised with no enabled pending source");

  chk_ack_in_service: assert property (
    (ack_hit && req_open) |=> insv_ff[$past(win_src)]
                              && iack_vector[4:0] == $past(win_src))
    else $error("served source not marked in service");

  chk_top_first: assert property (
    (ack_hit && top_used && eligible[top_src] && !isr_found)
      |=> iack_vector[4:0] == $past(top_src))
    else $error("top-priority source not served first");

  chk_slot_a_code: assert property (
    (ack_hit && req_open && req_idx == {1'b0, cmi_pkg::POS_A})
      |=> iack_vector[4:0] == cmi_pkg::SCC1_CODE - {3'h0, $past(slot_sel[1:0])})
    else $error("slot a channel code wrong");

  chk_one_cycle: assert property (
    iack_valid |=> !iack_valid || $past(ack_hit))
    else $error("answer held without new acknowledge");

  chk_cfg_reserved: assert property (
    (cfg_ff & ~cmi_pkg::CFG_WMASK) == '0)
    else $error("reserved configuration bits set");

  chk_src_reserved: assert property (
    ((pend_ff | mask_ff | insv_ff) & ~cmi_pkg::SRC_VALID) == '0)
    else $error("reserved source bit set");

  chk_served_eligible: assert property (
    (ack_hit && req_open) |-> eligible[win_src])
    else $error("served source not pending and enabled");

  chk_irq_level_value: assert property (
    (irq_level != cmi_pkg::LEVEL_OFF) |-> irq_level == $past(level))
    else $error("request level differs from configured level");

  chk_pend_cleared: assert property (
    (ack_hit && req_open) |=> !pend_ff[$past(win_src)] || $past(src_event[win_src]))
    else $error("served pending bit not cleared");

  chk_error_no_change: assert property (
    (ack_hit && !req_open && !wr_en && src_event == '0)
      |=> $stable(insv_ff) && $stable(pend_ff))
    else $error("error vector changed a register");

  chk_level_mismatch: assert property (
    (iack_req && iack_level != level) |=> !iack_valid)
    else $error("acknowledge at another level answered");

  chk_level_zero_idle: assert property (
    (iack_req && !level_on) |=> !iack_valid)
    else $error("acknowledge answered with level zero");

  chk_vector_holds: assert property (
    !ack_hit |=> $stable(iack_vector))
    else $error("vector changed without acknowledge");

  chk_prdata_stable: assert property (
    !rd_setup |=> $stable(prdata))
    else $error("read data changed outside a read");

  chk_cfg_write: assert property (
    (wr_en && sel_cfg) |=> cfg_ff == ($past(pwdata[23:0]) & cmi_pkg::CFG_WMASK))
    else $error("configuration write not taken");

  chk_mask_write: assert property (
    (wr_en && sel_mask) |=> mask_ff == ($past(pwdata) & cmi_pkg::SRC_VALID))
    else $error("mask write not taken");

  chk_slot_b_spread: assert property (
    (ack_hit && req_open && spread && req_idx == {1'b0, cmi_pkg::POS_B_SPR})
      |=> iack_vector[4:0] == cmi_pkg::SCC1_CODE - {3'h0, $past(slot_sel[3:2])})
    else $error("spread slot b channel code wrong");

  chk_slot_c_group: assert property (
    (ack_hit && req_open && !spread && req_idx == {1'b0, cmi_pkg::POS_C_GRP})
      |=> iack_vector[4:0] == cmi_pkg::SCC1_CODE - {3'h0, $past(slot_sel[5:4])})
    else $error("grouped slot c channel code wrong");

  chk_slot_d_group: assert property (
    (ack_hit && req_open && !spread && req_idx == {1'b0, cmi_pkg::POS_D_GRP})
      |=> iack_vector[4:0] == cmi_pkg::SCC1_CODE - {3'h0, $past(slot_sel[7:6])})
    else $error("grouped slot d channel code wrong");

  cov_served: cover property (ack_hit && req_open ##1 iack_valid);
  cov_error: cover property (ack_hit && !req_open ##1 iack_valid);
  cov_spread: cover property (ack_hit && req_open && spread);
  cov_nested: cover property (ack_hit && req_open && isr_found);
  cov_top: cover property (ack_hit && req_open && req_idx == cmi_pkg::TOP_POS);

endmodule : cmi_ctrl

// *** sim/cmi_core_model.sv ***
// Processor core model that runs interrupt acknowledge cycles
`timescale 1ns/1ps
module cmi_core_model (
  input  wire logic       sys_clk,
  input  wire logic       iack_valid,
  input  wire logic [7:0] iack_vector,
  output logic            iack_req,
  output logic [2:0]      iack_level
);
  initial
  begin
    iack_req   = 1'b0;
    iack_level = 3'h0;
  end

  // One acknowledge after lag idle cycles; ok stays low when no answer came
  task automatic ack(input logic [2:0] lvl, input int lag, output logic [7:0] vec,
                     output logic ok);
    repeat (lag) @(posedge sys_clk);
    iack_req   <= 1'b1;
    iack_level <= lvl;
    @(posedge sys_clk);
    iack_req   <= 1'b0;
    iack_level <= ~lvl;
    @(posedge sys_clk);
    ok  = iack_valid;
    // The error vector is taken like any other; its handler only returns
    vec = iack_vector;
  endtask : ack
endmodule : cmi_core_model

// *** sim/test_comm_module_interrupt_vectoring.sv ***
// Self-checking bench for the module interrupt controller
`timescale 1ns/1ps
module test_comm_module_interrupt_vectoring;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        iack_req, iack_valid, ok, e;
  logic [2:0]  irq_level, iack_level, lvl_v, base_v;
  logic [7:0]  iack_vector, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src_event, q;
  int          n_mismatch = 0;
  int          checked = 0;

  cmi_ctrl DUT (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .src_event(src_event), .irq_level(irq_level), .iack_req(iack_req),
    .iack_level(iack_level), .iack_valid(iack_valid), .iack_vector(iack_vector)
  );

  cmi_core_model core (
    .sys_clk(sys_clk), .iack_valid(iack_valid), .iack_vector(iack_vector),
    .iack_req(iack_req), .iack_level(iack_level)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask : rd

  task automatic cfg(input logic [7:0] slots, input logic [2:0] lvl, input logic [4:0] top,
                     input logic [2:0] base, input logic spr);
    lvl_v  = lvl;
    base_v = base;
    apb(1'b1, cmi_pkg::CFG_OFF, {8'h00, slots, lvl, top, base, 4'h0, spr});
  endtask : cfg

  task automatic fire(input logic [31:0] ev, input logic [2:0] exp_irq);
    src_event <= ev;
    @(posedge sys_clk);
    src_event <= 32'h00000000;
    repeat (2) @(posedge sys_clk);
    chk({29'h0, irq_level}, {29'h0, exp_irq});
  endtask : fire

  // Acknowledges k requests in turn, slower each time, freeing each in-service bit
  task automatic serve(input logic [19:0] codes, input int k);
    logic [7:0] sv;
    logic       sok;
    for (int i = 0; i < k; i++)
    begin
      core.ack(lvl_v, i, sv, sok);
      chk({31'h0, sok}, 32'h00000001);
      chk({24'h0, sv}, {24'h0, base_v, codes[19-5*i -: 5]});
      rd(cmi_pkg::INSV_OFF, 32'h00000001 << codes[19-5*i -: 5]);
      apb(1'b1, cmi_pkg::INSV_OFF, 32'h00000001 << codes[19-5*i -: 5]);
    end
  endtask : serve

  initial
  begin
    reset     = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h00000000;
    src_event = 32'h00000000;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(cmi_pkg::CFG_OFF, 32'h00000000);
    chk({31'h0, e}, 32'h00000000);
    rd(cmi_pkg::PEND_OFF, 32'h00000000);
    rd(cmi_pkg::MASK_OFF, 32'h00000000);
    rd(cmi_pkg::INSV_OFF, 32'h00000000);
    chk({29'h0, irq_level}, 32'h00000000);
    $display("test reset done");
    apb(1'b1, cmi_pkg::CFG_OFF, 32'hFFFFFFFF);
    rd(cmi_pkg::CFG_OFF, 32'h00FFFFE1);
    apb(1'b1, cmi_pkg::MASK_OFF, 32'hFFFFFFFF);
    rd(cmi_pkg::MASK_OFF, 32'hFFF6DEFE);
    rd(12'h010, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    $display("test registers done");
    cfg(8'hE4, 3'h4, 5'h1F, 3'h5, 1'b0);
    for (int n = 31; n > 0; n--)
    begin
      if (32'h00092100 & (32'h00000001 << n))
        fire(32'h00000001 << n, 3'h0);
      else
      begin
        fire(32'h00000001 << n, 3'h4);
        serve({5'(n), 15'h0}, 1);
      end
    end
    $display("test vectors done");
    cfg(8'h1B, 3'h4, 5'h1F, 3'h5, 1'b0);
    fire(32'h78000000, 3'h4);
    serve({5'h1B, 5'h1C, 5'h1D, 5'h1E}, 4);
    cfg(8'hE4, 3'h4, 5'h1F, 3'h2, 1'b1);
    fire(32'h28100080, 3'h4);
    serve({5'h14, 5'h1D, 5'h1B, 5'h07}, 4);
    cfg(8'hE4, 3'h7, 5'h01, 3'h7, 1'b0);
    fire(32'h80000002, 3'h7);
    serve({5'h01, 5'h1F, 10'h0}, 2);
    $display("test priority done");
    cfg(8'hE4, 3'h4, 5'h1F, 3'h5, 1'b0);
    apb(1'b1, cmi_pkg::MASK_OFF, 32'h00000000);
    fire(32'h00000020, 3'h0);
    rd(cmi_pkg::PEND_OFF, 32'h00000020);
    apb(1'b1, cmi_pkg::MASK_OFF, 32'h00000020);
    @(posedge sys_clk);
    chk({29'h0, irq_level}, 32'h00000004);
    apb(1'b1, cmi_pkg::MASK_OFF, 32'h00000000);
    core.ack(3'h4, 0, v, ok);
    chk({31'h0, ok}, 32'h00000001);
    chk({24'h0, v}, 32'h000000A0);
    rd(cmi_pkg::PEND_OFF, 32'h00000020);
    core.ack(3'h3, 0, v, ok);
    chk({31'h0, ok}, 32'h00000000);
    apb(1'b1, cmi_pkg::PEND_OFF, 32'h00000020);
    rd(cmi_pkg::PEND_OFF, 32'h00000000);
    cfg(8'hE4, 3'h0, 5'h1F, 3'h5, 1'b0);
    apb(1'b1, cmi_pkg::MASK_OFF, 32'hFFFFFFFF);
    fire(32'h00000020, 3'h0);
    $display("test mask and error done");
    conclude();
  end
endmodule : test_comm_module_interrupt_vectoring
